/* verilog/sfs_map.svh */
`ifndef SFS_MAP_SVH
`define SFS_MAP_SVH

// command codes
`define SFS_OP_SET_WLATCH  8'h06
`define SFS_OP_CLR_WLATCH  8'h04
`define SFS_OP_STAT_RD     8'h05
`define SFS_OP_STAT_WR     8'h01
`define SFS_OP_ARRAY_RD    8'h03
`define SFS_OP_PAGE_PROG   8'h02
`define SFS_OP_SECT_ERASE  8'hD8
`define SFS_OP_BULK_ERASE  8'hC7
`define SFS_OP_WAKE_ID     8'hAB
`define SFS_OP_MAKER_ID    8'h90
`define SFS_OP_JEDEC_ID    8'h9F
`define SFS_OP_OTP_ENTER   8'h3A

// status byte field positions
`define SFS_ST_BUSY        0
`define SFS_ST_WLATCH      1
`define SFS_ST_PROT_LO     2
`define SFS_ST_PROT_HI     4
`define SFS_ST_STPROT      7

// frame lengths in whole bytes, opcode included
`define SFS_LEN_SINGLE     3'h1
`define SFS_LEN_STAT_WR    3'h2
`define SFS_LEN_ADDR_LAST  3'h3
`define SFS_LEN_SECT       3'h4
`define SFS_LEN_PROG_MIN   3'h5
`define SFS_LEN_SAT        3'h7

// array address range
`define SFS_TOP_ADDR       24'h3F_FFFF
`define SFS_ZERO_ADDR      24'h00_0000

// start of the protected upper region for each nonzero protect-size code
`define SFS_PROT_BASE_1    22'h3F_F000
`define SFS_PROT_BASE_2    22'h3F_E000
`define SFS_PROT_BASE_3    22'h3F_C000
`define SFS_PROT_BASE_4    22'h3F_8000
`define SFS_PROT_BASE_5    22'h3F_0000
`define SFS_PROT_BASE_6    22'h20_0000
`define SFS_PROT_BASE_7    22'h00_0000

// pin levels while idle: chip select high, clock low, input low, wp high
`define SFS_PINS_IDLE      4'h9

// timing
`define SFS_CLK_NS         10
`define SFS_TW_NS          5000
`define SFS_TW_CYC         (16'((`SFS_TW_NS + `SFS_CLK_NS - 1) / `SFS_CLK_NS))

`endif

/* verilog/sfs_pkg.sv */
package sfs_pkg;

   typedef enum logic [1:0] {
      ST_OPCODE,
      ST_BODY,
      ST_IGNORE
   } sfs_phase_t;

   typedef enum logic [1:0] {
      OP_PROGRAM,
      OP_SECTOR,
      OP_BULK
   } sfs_op_t;

   typedef struct packed {
      logic chip_sel_n;
      logic sclk;
      logic serial_in;
      logic wp_n;
   } sfs_pins_t;

   typedef struct packed {
      sfs_pins_t meta;
      sfs_pins_t stable;
   } sfs_sync_t;

   typedef struct packed {
      sfs_phase_t  phase;
      sfs_pins_t   pins_prev;
      logic [6:0]  shift;
      logic [2:0]  bit_cnt;
      logic [2:0]  byte_cnt;
      logic [7:0]  opcode;
      logic [7:0]  tx;
      logic        out_en;
      logic        alt;
      logic [1:0]  id_idx;
      logic [23:0] addr;
      logic [7:0]  wdata;
      logic        write_enable_latch_flag;
      logic        status_protect_bit;
      logic [2:0]  protect_size;
      logic        otp_mode;
      logic        otp_lock;
      logic        hw_prot;
      logic [15:0] wr_cnt;
      logic        wr_busy;
      logic        wr_otp;
      logic [3:0]  wr_pend;
      logic        ext_run;
      logic        op_req;
      sfs_op_t     op_kind;
      logic        op_otp;
      logic        so;
      logic        so_oe;
   } sfs_core_t;

endpackage

/* verilog/sfs_pin_sync.sv */
`timescale 1ns/1ps
`include "sfs_map.svh"

module sfs_pin_sync
   import sfs_pkg::*;
(
   // clock and reset
   input  wire logic      ref_clk_i,
   input  wire logic      sys_rst_i,
   // raw pins and their synchronised copy
   input  wire sfs_pins_t pins_i,
   output sfs_pins_t      pins_o
);

   sfs_sync_t q;
   sfs_sync_t d;

   always_comb
   begin
      d        = q;
      d.meta   = pins_i;
      d.stable = q.meta;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         q <= {`SFS_PINS_IDLE, `SFS_PINS_IDLE};
      end
      else
      begin
         q <= d;
      end
   end

   assign pins_o = q.stable;

endmodule // sfs_pin_sync

/* verilog/sfs_core.sv */
`timescale 1ns/1ps
`include "sfs_map.svh"

module sfs_core
   import sfs_pkg::*;
#(
   parameter logic [15:0] TW_CYCLES  = `SFS_TW_CYC,
   parameter logic [7:0]  MAKER_CODE = 8'hA5,   // arbitrary value
   parameter logic [7:0]  PART_CODE  = 8'h5A,   // arbitrary value
   parameter logic [15:0] PART_WIDE  = 16'h3CC3 // arbitrary value
)
(
   // clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        sys_rst_i,
   // serial bus pins
   input  wire logic        chip_sel_n_i,
   input  wire logic        sclk_i,
   input  wire logic        serial_in_i,
   input  wire logic        wp_n_i,
   output logic             so_o,
   output logic             so_oe_o,
   // array read port
   output logic [23:0]      addr_o,
   input  wire logic [7:0]  mem_data_i,
   // program and erase engine
   output logic             op_req_o,
   output sfs_op_t          op_kind_o,
   output logic             op_otp_o,
   input  wire logic        op_done_i,
   // mode indication
   output logic             otp_mode_o,
   output logic             hw_protect_o
);

   sfs_core_t  q;
   sfs_core_t  n;
   sfs_pins_t  s;
   sfs_pins_t  raw;
   logic [7:0] rx;
   logic [7:0] stat;
   logic       busy;
   logic       rise;
   logic       fall;
   logic       grant;
   logic       out_bit;

   assign raw = '{chip_sel_n: chip_sel_n_i, sclk: sclk_i, serial_in: serial_in_i, wp_n: wp_n_i};

   sfs_pin_sync u_sync (
      .ref_clk_i (ref_clk_i),
      .sys_rst_i (sys_rst_i),
      .pins_i    (raw),
      .pins_o    (s)
   );

   function automatic logic region_hit(input logic [2:0] size, input logic [23:0] a);
      logic [21:0] base;
      base = `SFS_PROT_BASE_7;
      if (size == 3'h1)
         base = `SFS_PROT_BASE_1;
      else if (size == 3'h2)
         base = `SFS_PROT_BASE_2;
      else if (size == 3'h3)
         base = `SFS_PROT_BASE_3;
      else if (size == 3'h4)
         base = `SFS_PROT_BASE_4;
      else if (size == 3'h5)
         base = `SFS_PROT_BASE_5;
      else if (size == 3'h6)
         base = `SFS_PROT_BASE_6;
      return (size != 3'h0) && (a[21:0] >= base);
   endfunction

   // true when a program or erase to this address may not proceed
   function automatic logic guarded(input sfs_core_t c, input logic [23:0] a);
      return c.otp_mode ? c.otp_lock : region_hit(c.protect_size, a);
   endfunction

   always_comb
   begin
      n          = q;
      n.op_req   = 1'b0;
      n.pins_prev = s;
      rise       = s.sclk & ~q.pins_prev.sclk;
      fall       = ~s.sclk & q.pins_prev.sclk;
      busy       = q.wr_busy | q.ext_run;
      rx         = {q.shift, s.serial_in};
      stat       = 8'h00;
      stat[`SFS_ST_BUSY]   = busy;
      stat[`SFS_ST_WLATCH] = q.write_enable_latch_flag;
      stat[`SFS_ST_PROT_HI:`SFS_ST_PROT_LO] = q.protect_size;
      stat[`SFS_ST_STPROT] = q.otp_mode ? q.otp_lock : q.status_protect_bit;
      grant      = q.write_enable_latch_flag & ~busy;
      out_bit    = (q.opcode == `SFS_OP_ARRAY_RD) ? mem_data_i[~q.bit_cnt] : q.tx[~q.bit_cnt];
      n.hw_prot  = q.status_protect_bit & ~s.wp_n;

      // self-timed status write
      if (q.wr_busy)
      begin
         if (q.wr_cnt == 16'h0000)
         begin
            n.wr_busy                 = 1'b0;
            n.write_enable_latch_flag = 1'b0;
            if (q.wr_otp)
            begin
               n.otp_lock = 1'b1;
            end
            else
            begin
               n.status_protect_bit = q.wr_pend[3];
               n.protect_size       = q.wr_pend[2:0];
            end
         end
         else
         begin
            n.wr_cnt = q.wr_cnt - 16'h0001;
         end
      end

      if (op_done_i && q.ext_run)
      begin
         n.ext_run                 = 1'b0;
         n.write_enable_latch_flag = 1'b0;
      end

      if (s.chip_sel_n)
      begin
         n.phase    = ST_OPCODE;
         n.bit_cnt  = 3'h0;
         n.byte_cnt = 3'h0;
         n.out_en   = 1'b0;
         n.so_oe    = 1'b0;
         n.so       = 1'b0;
         // frame end: act only on whole bytes of a known command
         if (!q.pins_prev.chip_sel_n && q.phase == ST_BODY && q.bit_cnt == 3'h0)
         begin
            case (q.opcode)
               `SFS_OP_SET_WLATCH:
               begin
                  if (q.byte_cnt == `SFS_LEN_SINGLE)
                     n.write_enable_latch_flag = 1'b1;
               end
               `SFS_OP_CLR_WLATCH:
               begin
                  if (q.byte_cnt == `SFS_LEN_SINGLE)
                  begin
                     n.write_enable_latch_flag = 1'b0;
                     n.otp_mode                = 1'b0;
                  end
               end
               `SFS_OP_OTP_ENTER:
               begin
                  if (q.byte_cnt == `SFS_LEN_SINGLE && !busy)
                     n.otp_mode = 1'b1;
               end
               `SFS_OP_STAT_WR:
               begin
                  if (q.byte_cnt == `SFS_LEN_STAT_WR && grant && !q.hw_prot)
                  begin
                     n.wr_busy = 1'b1;
                     n.wr_cnt  = TW_CYCLES - 16'h0001;
                     n.wr_otp  = q.otp_mode;
                     n.wr_pend = {q.wdata[`SFS_ST_STPROT],
                                  q.wdata[`SFS_ST_PROT_HI:`SFS_ST_PROT_LO]};
                  end
               end
               `SFS_OP_PAGE_PROG:
               begin
                  if (q.byte_cnt >= `SFS_LEN_PROG_MIN && grant && !guarded(q, q.addr))
                  begin
                     n.op_req  = 1'b1;
                     n.op_kind = OP_PROGRAM;
                     n.op_otp  = q.otp_mode;
                     n.ext_run = 1'b1;
                  end
               end
               `SFS_OP_SECT_ERASE:
               begin
                  if (q.byte_cnt == `SFS_LEN_SECT && grant && !guarded(q, q.addr))
                  begin
                     n.op_req  = 1'b1;
                     n.op_kind = OP_SECTOR;
                     n.op_otp  = q.otp_mode;
                     n.ext_run = 1'b1;
                  end
               end
               `SFS_OP_BULK_ERASE:
               begin
                  if (q.byte_cnt == `SFS_LEN_SINGLE && grant &&
                      (q.otp_mode ? !q.otp_lock : q.protect_size == 3'h0))
                  begin
                     n.op_req  = 1'b1;
                     n.op_kind = OP_BULK;
                     n.op_otp  = q.otp_mode;
                     n.ext_run = 1'b1;
                  end
               end
               default:
               begin
               end
            endcase
         end
      end
      else
      begin
         if (rise)
         begin
            n.shift   = rx[6:0];
            n.bit_cnt = q.bit_cnt + 3'h1;
            if (q.bit_cnt == 3'h7)
            begin
               n.byte_cnt = (q.byte_cnt == `SFS_LEN_SAT) ? q.byte_cnt : q.byte_cnt + 3'h1;
               if (q.phase == ST_OPCODE)
               begin
                  n.opcode = rx;
                  n.phase  = ST_BODY;
                  case (rx)
                     `SFS_OP_STAT_RD:
                     begin
                        n.out_en = 1'b1;
                        n.tx     = stat;
                     end
                     `SFS_OP_JEDEC_ID:
                     begin
                        n.out_en = 1'b1;
                        n.tx     = MAKER_CODE;
                        n.id_idx = 2'h1;
                     end
                     `SFS_OP_ARRAY_RD:
                     begin
                        if (busy)
                           n.phase = ST_IGNORE;
                     end
                     `SFS_OP_WAKE_ID, `SFS_OP_MAKER_ID, `SFS_OP_STAT_WR,
                     `SFS_OP_PAGE_PROG, `SFS_OP_SECT_ERASE, `SFS_OP_BULK_ERASE,
                     `SFS_OP_SET_WLATCH, `SFS_OP_CLR_WLATCH, `SFS_OP_OTP_ENTER:
                     begin
                     end
                     default:
                     begin
                        n.phase = ST_IGNORE;
                     end
                  endcase
               end
               else if (q.phase == ST_BODY)
               begin
                  case (q.opcode)
                     `SFS_OP_STAT_RD:
                     begin
                        n.tx = stat;
                     end
                     `SFS_OP_ARRAY_RD, `SFS_OP_PAGE_PROG, `SFS_OP_SECT_ERASE:
                     begin
                        if (q.byte_cnt <= `SFS_LEN_ADDR_LAST)
                        begin
                           n.addr = {q.addr[15:0], rx};
                           if (q.byte_cnt == `SFS_LEN_ADDR_LAST && q.opcode == `SFS_OP_ARRAY_RD)
                              n.out_en = 1'b1;
                        end
                        else if (q.opcode == `SFS_OP_ARRAY_RD)
                        begin
                           n.addr = (q.addr == `SFS_TOP_ADDR) ? `SFS_ZERO_ADDR
                                                              : q.addr + 24'h00_0001;
                        end
                     end
                     `SFS_OP_WAKE_ID:
                     begin
                        if (q.byte_cnt >= `SFS_LEN_ADDR_LAST)
                           n.out_en = 1'b1;
                        n.tx = PART_CODE;
                     end
                     `SFS_OP_MAKER_ID:
                     begin
                        if (q.byte_cnt == `SFS_LEN_ADDR_LAST)
                        begin
                           n.out_en = 1'b1;
                           n.alt    = rx[0];
                        end
                        else
                        begin
                           n.alt = ~q.alt;
                        end
                        n.tx = n.alt ? PART_CODE : MAKER_CODE;
                     end
                     `SFS_OP_JEDEC_ID:
                     begin
                        if (q.id_idx == 2'h1)
                           n.tx = PART_WIDE[15:8];
                        else if (q.id_idx == 2'h2)
                           n.tx = PART_WIDE[7:0];
                        else
                           n.tx = MAKER_CODE;
                        n.id_idx = (q.id_idx == 2'h2) ? 2'h0 : q.id_idx + 2'h1;
                     end
                     `SFS_OP_STAT_WR:
                     begin
                        if (q.byte_cnt == `SFS_LEN_SINGLE)
                           n.wdata = rx;
                     end
                     default:
                     begin
                     end
                  endcase
               end
            end
         end
         if (fall && q.out_en)
         begin
            n.so    = out_bit;
            n.so_oe = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         q           <= '0;
         q.pins_prev <= `SFS_PINS_IDLE;
      end
      else
      begin
         q <= n;
      end
   end

   assign so_o         = q.so;
   assign so_oe_o      = q.so_oe;
   assign addr_o       = q.addr;
   assign op_req_o     = q.op_req;
   assign op_kind_o    = q.op_kind;
   assign op_otp_o     = q.op_otp;
   assign otp_mode_o   = q.otp_mode;
   assign hw_protect_o = q.hw_prot;

endmodule // sfs_core

/* testbench/sfs_core_monitor.sv */
`timescale 1ns/1ps
module sfs_core_monitor
(
   // clock, reset and watched ports
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic chip_sel_n_i,
   input wire logic sclk_i,
   input wire logic wp_n_i,
   input wire logic so_o,
   input wire logic so_oe_o,
   input wire logic op_req_o,
   input wire logic otp_mode_o,
   input wire logic hw_protect_o
);
   default clocking mon_cb @(posedge ref_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   sequence cs_idle_s;
      chip_sel_n_i [*5];
   endsequence
   sequence wp_high_s;
      wp_n_i [*5];
   endsequence
   // deselected now and two samples back
   sequence gap_s;
      chip_sel_n_i && $past(chip_sel_n_i, 2);
   endsequence

   AST_RESET_QUIET: assert property (disable iff (1'b0)
      sys_rst_i |=> !so_oe_o && !op_req_o && !otp_mode_o && !hw_protect_o)
      else $error("outputs not idle after reset");
   AST_OE_IDLE: assert property (cs_idle_s |-> !so_oe_o)
      else $error("serial out driven while deselected");
   AST_OE_START: assert property ($rose(so_oe_o) |-> !$past(chip_sel_n_i, 3))
      else $error("serial out enabled outside a frame");
   AST_SO_ON_FALL: assert property ($changed(so_o) |-> !$past(sclk_i, 2))
      else $error("serial out moved while clock high");
   AST_OP_FRAME: assert property (op_req_o |-> gap_s ##1 !op_req_o)
      else $error("engine request not a pulse after frame end");
   AST_HWP_NEEDS_WP: assert property ($rose(hw_protect_o) |-> !$past(wp_n_i, 2))
      else $error("hardware protect without protect pin low");
   AST_HWP_RELEASE: assert property (wp_high_s |-> !hw_protect_o)
      else $error("hardware protect with protect pin high");
   AST_OTP_GAP: assert property ($changed(otp_mode_o) |-> gap_s)
      else $error("otp mode changed inside a frame");
endmodule // sfs_core_monitor

bind sfs_core sfs_core_monitor mon_u (
   .ref_clk_i    (ref_clk_i),
   .sys_rst_i    (sys_rst_i),
   .chip_sel_n_i (chip_sel_n_i),
   .sclk_i       (sclk_i),
   .wp_n_i       (wp_n_i),
   .so_o         (so_o),
   .so_oe_o      (so_oe_o),
   .op_req_o     (op_req_o),
   .otp_mode_o   (otp_mode_o),
   .hw_protect_o (hw_protect_o)
);

/* testbench/sfs_host_model.sv */
`timescale 1ns/1ps
module sfs_host_model
(
   // bus towards the device
   output logic        chip_sel_n_o,
   output logic        sclk_o,
   output logic        serial_in_o,
   input  wire logic   so_i,
   input  wire logic   so_oe_i,
   // bits returned in the last frame
   output logic [63:0] rx_o,
   output logic        rx_stb_o
);
   initial
   begin
      chip_sel_n_o = 1'b1;
      sclk_o       = 1'b0;
      serial_in_o  = 1'b0;
      rx_o         = '0;
      rx_stb_o     = 1'b0;
   end

   // one frame; clock stands low between frames
   task automatic xfer(input int nbits, input logic [63:0] tx);
      rx_o = '0;
      chip_sel_n_o = 1'b0;
      #62.5;
      for (int i = nbits - 1; i >= 0; i--)
      begin
         serial_in_o = tx[i];
         #62.5 sclk_o = 1'b1;
         rx_o = {rx_o[62:0], so_oe_i & so_i};
         #62.5 sclk_o = 1'b0;
      end
      #62.5 chip_sel_n_o = 1'b1;
      serial_in_o = ~serial_in_o;
      rx_stb_o = ~rx_stb_o;
      #125;
   endtask
endmodule // sfs_host_model

/* testbench/tb_serial_flash_status_read.sv */
`timescale 1ns/1ps
module tb_serial_flash_status_read;
   import sfs_pkg::*;

   typedef struct packed {
      logic [63:0] val;
      logic [63:0] msk;
   } sfs_note_t;

   localparam logic [15:0] TW    = 16'h03E8;
   localparam logic [7:0]  MAKER = 8'hB7;    // arbitrary value
   localparam logic [7:0]  PART  = 8'h6D;    // arbitrary value
   localparam logic [15:0] WIDE  = 16'hE419; // arbitrary value

   logic        ref_clk_i;
   logic        sys_rst_i = 1'b1;
   logic        wp_n_i    = 1'b1;
   logic        op_done_i = 1'b0;
   logic        cs_n;
   logic        sclk;
   logic        sdi;
   logic        so;
   logic        so_oe;
   logic [23:0] addr;
   logic [7:0]  mem_data;
   logic        op_req;
   sfs_op_t     op_kind;
   logic        op_otp;
   logic [63:0] rx;
   logic        rx_stb;
   logic        otp_mode;
   logic        hw_prot;
   sfs_note_t   notes_q[$];
   int          num_errors  = 0;
   int          check_count = 0;
   int          eng_cnt     = 0;

   initial
   begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end

   function automatic logic [7:0] mem_at(input logic [23:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5C;
   endfunction

   assign mem_data = mem_at(addr);

   sfs_core #(
      .TW_CYCLES  (TW),
      .MAKER_CODE (MAKER),
      .PART_CODE  (PART),
      .PART_WIDE  (WIDE)
   ) dut_u (
      .ref_clk_i    (ref_clk_i),
      .sys_rst_i    (sys_rst_i),
      .chip_sel_n_i (cs_n),
      .sclk_i       (sclk),
      .serial_in_i  (sdi),
      .wp_n_i       (wp_n_i),
      .so_o         (so),
      .so_oe_o      (so_oe),
      .addr_o       (addr),
      .mem_data_i   (mem_data),
      .op_req_o     (op_req),
      .op_kind_o    (op_kind),
      .op_otp_o     (op_otp),
      .op_done_i    (op_done_i),
      .otp_mode_o   (otp_mode),
      .hw_protect_o (hw_prot)
   );

   sfs_host_model host_u (
      .chip_sel_n_o (cs_n),
      .sclk_o       (sclk),
      .serial_in_o  (sdi),
      .so_i         (so),
      .so_oe_i      (so_oe),
      .rx_o         (rx),
      .rx_stb_o     (rx_stb)
   );

   task automatic final_report();
      if (num_errors == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic take(input logic [63:0] got);
      sfs_note_t n;
      n = '{val: ~got, msk: '1};
      if (notes_q.size() > 0)
         n = notes_q.pop_front();
      check_count++;
      if ((got & n.msk) !== (n.val & n.msk))
      begin
         num_errors++;
         $display("BAD %0t got %h want %h", $time, got & n.msk, n.val & n.msk);
      end
   endtask

   // level output compared directly, frames are long enough for it to settle
   task automatic flag(input logic got, input logic want);
      check_count++;
      if (got !== want)
      begin
         num_errors++;
         $display("BAD %0t flag got %b want %b", $time, got, want);
      end
   endtask

   task automatic fr(input int nb, input logic [63:0] tx, input logic [63:0] v,
                     input logic [63:0] m);
      notes_q.push_back('{val: v, msk: m});
      host_u.xfer(nb, tx);
   endtask

   // frame followed by one engine request
   task automatic pr(input int nb, input logic [63:0] tx, input logic [26:0] v,
                     input logic [26:0] m);
      notes_q.push_back('{val: '0, msk: '0});
      notes_q.push_back('{val: {37'h0, v}, msk: {37'h0, m}});
      host_u.xfer(nb, tx);
   endtask

   task automatic st(input logic [7:0] e);
      fr(16, 64'h0500, {56'h0, e}, 64'hFF);
   endtask

   task automatic rd(input logic [21:0] a);
      fr(56, {8'h0, 8'h03, 2'b00, a, 24'h0}, {40'h0, mem_at({2'b00, a}),
         mem_at({2'b00, a + 22'd1}), mem_at({2'b00, a + 22'd2})}, 64'hFF_FFFF);
   endtask

   // status write time is fixed, then the engine gets a bounded wait
   task automatic settle();
      repeat (int'(TW) + 20) @(negedge ref_clk_i);
      for (int k = 0; eng_cnt != 0; k++)
      begin
         if (k == 200)
         begin
            num_errors++;
            $display("BAD %0t engine never finished", $time);
            final_report();
         end
         @(negedge ref_clk_i);
      end
   endtask

   always @(rx_stb)
      if ($time > 0)
         take(rx);

   // program and erase engine
   always @(negedge ref_clk_i)
   begin
      op_done_i <= (eng_cnt == 1);
      if (eng_cnt > 0)
         eng_cnt <= eng_cnt - 1;
      if (op_req === 1'b1)
      begin
         take({37'h0, op_otp, op_kind, addr});
         eng_cnt <= 20 + int'($urandom % 64);
      end
   end

   initial
   begin
      void'($urandom(32'ha9a0));
      repeat (10) @(negedge ref_clk_i);
      sys_rst_i = 1'b0;
      repeat (5) @(negedge ref_clk_i);
      st(8'h00);
      fr(8, 64'h06, 0, 0);
      st(8'h02);
      fr(8, 64'h04, 0, 0);
      st(8'h00);
      fr(9, 64'h0C, 0, 0);
      fr(7, 64'h03, 0, 0);
      st(8'h00);
      fr(16, 64'h01FF, 0, 0);
      st(8'h00);
      fr(8, 64'h06, 0, 0);
      fr(15, 64'h00FF, 0, 0);
      fr(24, 64'h01_FF00, 0, 0);
      st(8'h02);
      fr(16, 64'h01FF, 0, 0);
      fr(24, 64'h05_0000, 64'h0303, 64'hFFFF);
      fr(40, 64'h03_3FFF_FE00, 0, 64'hFF);
      settle();
      st(8'h9C);
      @(negedge ref_clk_i) wp_n_i = 1'b0;
      fr(8, 64'h06, 0, 0);
      fr(16, 64'h0100, 0, 0);
      st(8'h9E);
      flag(hw_prot, 1'b1);
      @(negedge ref_clk_i) wp_n_i = 1'b1;
      fr(16, 64'h0100, 0, 0);
      settle();
      st(8'h00);
      flag(hw_prot, 1'b0);
      fr(8, 64'h06, 0, 0);
      fr(16, 64'h0104, 0, 0);
      settle();
      fr(8, 64'h06, 0, 0);
      fr(40, 64'h02_3FF0_00AA, 0, 0);
      fr(8, 64'hC7, 0, 0);
      st(8'h06);
      pr(40, 64'h02_3FEF_FFAA, {1'b0, OP_PROGRAM, 24'h3F_EFFF}, '1);
      settle();
      st(8'h04);
      fr(8, 64'h06, 0, 0);
      fr(16, 64'h0100, 0, 0);
      settle();
      fr(8, 64'h06, 0, 0);
      pr(8, 64'hC7, {1'b0, OP_BULK, 24'h0}, {3'h7, 24'h0});
      settle();
      fr(8, 64'h06, 0, 0);
      pr(32, 64'hD812_3456, {1'b0, OP_SECTOR, 24'h12_3456}, '1);
      settle();
      st(8'h00);
      rd(22'h3F_FFFE);
      rd(22'($urandom));
      fr(56, 64'h90_0000_0000_0000, {40'h0, MAKER, PART, MAKER}, 64'hFF_FFFF);
      fr(56, 64'h90_0000_0100_0000, {40'h0, PART, MAKER, PART}, 64'hFF_FFFF);
      fr(48, 64'hAB00_0000_0000, {48'h0, PART, PART}, 64'hFFFF);
      fr(40, 64'h9F_0000_0000, {32'h0, MAKER, WIDE, MAKER}, 64'hFFFF_FFFF);
      fr(24, 64'hFF_0500, 0, 64'hFFFF);
      st(8'h00);
      fr(8, 64'h3A, 0, 0);
      st(8'h00);
      flag(otp_mode, 1'b1);
      fr(8, 64'h06, 0, 0);
      pr(40, 64'h02_0000_1055, {1'b1, OP_PROGRAM, 24'h00_0010}, '1);
      settle();
      fr(8, 64'h06, 0, 0);
      fr(16, 64'h0100, 0, 0);
      settle();
      st(8'h80);
      fr(8, 64'h06, 0, 0);
      fr(40, 64'h02_0000_2055, 0, 0);
      st(8'h82);
      fr(8, 64'h04, 0, 0);
      st(8'h00);
      flag(otp_mode, 1'b0);
      repeat (20) @(negedge ref_clk_i);
      final_report();
   end
endmodule // tb_serial_flash_status_read
